//--- shared/l2_hint_params.svh
/*
  Offsets, field positions, reset values and build choices of the
  level-2 hint and preload port.
  Assumes an 8-bit register address and 32-bit register data.
*/
`ifndef L2_HINT_PARAMS_SVH
`define L2_HINT_PARAMS_SVH

// ==========================================================
// register offsets (byte addresses)
`define OFF_AUX 8'h00
`define OFF_ID 8'h04
`define OFF_ACT 8'h08
`define OFF_FREE 8'h0c
`define OFF_BASE 8'h10
`define OFF_SC 8'h14
`define OFF_TTB 8'h18
`define OFF_CTX 8'h1c
`define OFF_GO 8'h20

// ==========================================================
// fields and reset values
`define AUX_PF_BIT 1
`define AUX_ZL_BIT 3
`define AUX_MASK 32'h0000000a
`define AUX_RST 32'h00000000
`define SC_CNT_LSB 16
`define CTX_NS_BIT 8
`define ID_SIZE_LSB 16
`define ARU_HINT 5
`define AWU_ZERO 7
`define AWU_EARLY 8

// ==========================================================
// build choices
`define FIFO_DEPTH 16
`define MP_BUILD 1'b1

`endif

//--- shared/l2_hint_pkg.sv
/*
  Types shared by the hint port, its preload queue and the queue link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package l2_hint_pkg;

  typedef logic [11:0] blk_count_t;

  // 100-bit preload queue entry
  typedef struct packed {
    logic [31:0] base;
    logic [15:0] stride;
    blk_count_t count;
    logic valid;
    logic ns;
    logic [29:0] translation_table_base;
    logic [7:0] address_space_tag;
  } ple_entry_t;

  typedef enum logic [1:0] {CH_IDLE, CH_XLAT, CH_ISSUE} chan_state_t;

  function automatic logic tag_match(ple_entry_t e, logic [7:0] tag);
    return e.valid && (e.address_space_tag == tag);
  endfunction

endpackage

//--- shared/ple_fifo_if.sv
/*
  Link between the preload engine and its entry queue.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ple_fifo_if;
  import l2_hint_pkg::*;
  logic push;
  ple_entry_t push_entry;
  logic pop;
  ple_entry_t head;
  logic nonempty;
  logic flush;
  logic inval;
  logic [7:0] inval_tag;
  logic [4:0] free;
  modport owner (output push, push_entry, pop, flush, inval, inval_tag, input head, nonempty, free);
  modport store (input push, push_entry, pop, flush, inval, inval_tag, output head, nonempty, free);
endinterface

//--- rtl/access_attr.sv
/*
  Protection privilege bit and store-buffer merge permission.
  Assumes the caller supplies the memory type and barrier history.
*/
`timescale 1ns/1ps
module access_attr (
  input wire logic user_mode,
  input wire logic cacheable,
  input wire logic is_write,
  input wire logic unpriv_store,
  input wire logic mem_strong,
  input wire logic mem_device,
  input wire logic barrier_seen,
  output logic priv,
  output logic merge_ok
);
  // ==========================================================
  // privilege
  always_comb begin
    if (!is_write) begin
      priv = !user_mode;
    end else if (cacheable) begin
      priv = 1'b1;
    end else begin
      priv = !user_mode && !unpriv_store;
    end
  end

  // ==========================================================
  // merging
  // ordered memory never merges
  assign merge_ok = !mem_strong && !mem_device && !(unpriv_store && barrier_seen);
endmodule

//--- rtl/preload_fifo.sv
/*
  Preload entry queue held in flip-flops.
  Assumes the owner pops only while nonempty and never pushes when full.
*/
`timescale 1ns/1ps
`include "l2_hint_params.svh"
module preload_fifo
  import l2_hint_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  ple_fifo_if.store fq
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    ple_entry_t [DEPTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic do_pop;
  logic do_push;

  assign do_pop = fq.pop && st.cnt != '0;
  assign do_push = fq.push && (st.cnt != FULL || do_pop);
  assign fq.head = st.mem[st.rp];
  assign fq.nonempty = st.cnt != '0;
  assign fq.free = 5'(FULL - st.cnt);

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    if (fq.flush) begin
      next_st.cnt = '0;
      next_st.wp = '0;
      next_st.rp = '0;
    end else begin
      if (fq.inval) begin
        for (int i = 0; i < DEPTH; i++) begin
          if (tag_match(st.mem[i], fq.inval_tag)) begin
            next_st.mem[i].valid = 1'b0;
          end
        end
      end
      if (do_pop) begin
        next_st.rp = st.rp + 1'b1;
      end
      if (do_push) begin
        next_st.mem[st.wp] = fq.push_entry;
        next_st.wp = st.wp + 1'b1;
      end
      next_st.cnt = st.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  count_bound_a: assert property (st.cnt <= FULL) else $error("queue count beyond depth");
  flush_empty_a: assert property (fq.flush |=> fq.free == 5'(FULL)) else $error("flush left entries");
  free_track_a: assert property (fq.push && !fq.pop && !fq.flush && st.cnt != FULL |=> fq.free == $past(fq.free) - 5'h1)
    else $error("free count not reduced by push");
endmodule

//--- rtl/l2_hint_and_preload_port.sv
/*
  Level-2 port front end: hint marking, early response and zero-line user
  bits, protection attributes and the preload engine with its queue.
  Assumes a register master, an address translator for preload lines and
  a level-2 slave that handles hint reads without returning data.
*/
`timescale 1ns/1ps
`include "l2_hint_params.svh"

module l2_hint_and_preload_port
  import l2_hint_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter bit MULTI_CORE = `MP_BUILD
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic user_mode,
  input wire logic nonsecure_flag,
  input wire logic core_ar_valid,
  output logic core_ar_ready,
  input wire logic [31:0] core_ar_addr,
  input wire logic [3:0] core_ar_attr,
  input wire logic core_ar_shared,
  input wire logic core_ar_cacheable,
  input wire logic core_aw_valid,
  output logic core_aw_ready,
  input wire logic [31:0] core_aw_addr,
  input wire logic [3:0] core_aw_attr,
  input wire logic core_aw_shared,
  input wire logic core_aw_cacheable,
  input wire logic core_aw_zero_line,
  input wire logic core_aw_unpriv_store,
  input wire logic sb_mem_strong,
  input wire logic sb_mem_device,
  input wire logic sb_unpriv_store,
  output logic sb_merge_ok,
  input wire logic data_sync_barrier,
  input wire logic mmu_cfg_write,
  input wire logic tlb_inval_tag,
  input wire logic tlb_inval_all,
  input wire logic [7:0] tlb_tag,
  output logic xlat_req,
  output logic [31:0] xlat_va,
  output logic [29:0] xlat_ttb,
  output logic [7:0] xlat_tag,
  output logic xlat_nonsecure,
  input wire logic xlat_done,
  input wire logic xlat_abort,
  input wire logic [31:0] xlat_pa,
  output logic arvalid,
  input wire logic arready,
  output logic [31:0] araddr,
  output logic [6:0] aruser,
  output logic [2:0] arprot,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] awaddr,
  output logic [8:0] awuser,
  output logic [2:0] awprot,
  input wire logic bvalid,
  output logic bready
);
  localparam logic [4:0] DEPTH5 = 5'(DEPTH);
  localparam logic [6:0] HINT_USER = 7'h01 << `ARU_HINT;

  typedef struct packed {
    logic [31:0] aux;
    logic [31:0] prog_base;
    logic [31:0] prog_sc;
    logic [29:0] prog_ttb;
    logic [8:0] prog_ctx;
    logic [31:0] rdata;
    chan_state_t ch;
    ple_entry_t cur;
    logic [31:0] hint_addr;
    logic arv;
    logic [31:0] araddr;
    logic [6:0] aruser;
    logic [2:0] arprot;
    logic awv;
    logic [31:0] awaddr;
    logic [8:0] awuser;
    logic [2:0] awprot;
    logic [31:0] pf_last;
    logic [31:0] pf_stride;
    logic pf_pend;
    logic [31:0] pf_addr;
    logic dsb_seen;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;
  ple_fifo_if fq ();
  logic ar_free;
  logic aw_free;
  logic ple_take;
  logic auto_on;
  logic auto_take;
  logic flush_all;
  logic chan_hit;
  logic rd_step;
  logic [31:0] rd_delta;
  logic rd_priv;
  logic wr_priv;

  // one line per block; stride may cross pages freely
  function automatic ple_entry_t next_block(ple_entry_t e);
    ple_entry_t r;
    r = e;
    r.base = e.base + 32'(e.stride);
    r.count = e.count - blk_count_t'(1);
    return r;
  endfunction

  function automatic chan_state_t after_block(ple_entry_t e);
    return (e.count == blk_count_t'(1)) ? CH_IDLE : CH_XLAT;
  endfunction

  // ==========================================================
  // submodules
  preload_fifo #(.DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fq(fq.store)
  );

  access_attr u_rd_attr (
    .user_mode(user_mode),
    .cacheable(core_ar_cacheable),
    .is_write(1'b0),
    .unpriv_store(1'b0),
    .mem_strong(1'b0),
    .mem_device(1'b0),
    .barrier_seen(1'b0),
    .priv(rd_priv),
    .merge_ok()
  );

  access_attr u_wr_attr (
    .user_mode(user_mode),
    .cacheable(core_aw_cacheable),
    .is_write(1'b1),
    .unpriv_store(core_aw_unpriv_store),
    .mem_strong(1'b0),
    .mem_device(1'b0),
    .barrier_seen(1'b0),
    .priv(wr_priv),
    .merge_ok()
  );

  access_attr u_sb_attr (
    .user_mode(user_mode),
    .cacheable(1'b0),
    .is_write(1'b1),
    .unpriv_store(sb_unpriv_store),
    .mem_strong(sb_mem_strong),
    .mem_device(sb_mem_device),
    .barrier_seen(st.dsb_seen),
    .priv(),
    .merge_ok(sb_merge_ok)
  );

  // ==========================================================
  // handshakes and queue control
  assign ar_free = !st.arv || arready;
  assign aw_free = !st.awv || awready;
  assign core_ar_ready = ar_free;
  assign core_aw_ready = aw_free;
  // core reads first; hints only fill idle slots
  assign ple_take = ar_free && !core_ar_valid && st.ch == CH_ISSUE;
  assign auto_on = MULTI_CORE && st.aux[`AUX_PF_BIT];
  assign auto_take = ar_free && !core_ar_valid && !ple_take && st.pf_pend && auto_on;
  assign flush_all = mmu_cfg_write || tlb_inval_all;
  assign chan_hit = tlb_inval_tag && tag_match(st.cur, tlb_tag);
  assign rd_step = core_ar_valid && ar_free;
  assign rd_delta = core_ar_addr - st.pf_last;

  assign fq.flush = flush_all;
  assign fq.inval = tlb_inval_tag;
  assign fq.inval_tag = tlb_tag;
  assign fq.push = reg_wr && reg_addr == `OFF_GO && fq.free != 5'h00;
  assign fq.push_entry = '{base: st.prog_base, stride: st.prog_sc[15:0],
                           count: st.prog_sc[`SC_CNT_LSB +: $bits(blk_count_t)], valid: 1'b1,
                           ns: st.prog_ctx[`CTX_NS_BIT], translation_table_base: st.prog_ttb, address_space_tag: st.prog_ctx[7:0]};
  assign fq.pop = st.ch == CH_IDLE && fq.nonempty && !flush_all;

  // ==========================================================
  // outputs
  assign reg_rdata = st.rdata;
  assign xlat_req = st.ch == CH_XLAT;
  assign xlat_va = st.cur.base;
  assign xlat_ttb = st.cur.translation_table_base;
  assign xlat_tag = st.cur.address_space_tag;
  assign xlat_nonsecure = st.cur.ns;
  assign arvalid = st.arv;
  assign araddr = st.araddr;
  assign aruser = st.aruser;
  assign arprot = st.arprot;
  assign awvalid = st.awv;
  assign awaddr = st.awaddr;
  assign awuser = st.awuser;
  assign awprot = st.awprot;
  // responses may precede data, so always take them
  assign bready = 1'b1;

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        `OFF_AUX: next_st.aux = reg_wdata & `AUX_MASK;
        `OFF_BASE: next_st.prog_base = reg_wdata;
        `OFF_SC: next_st.prog_sc = reg_wdata;
        `OFF_TTB: next_st.prog_ttb = reg_wdata[29:0];
        `OFF_CTX: next_st.prog_ctx = reg_wdata[8:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `OFF_AUX: next_st.rdata = st.aux;
        `OFF_ID: next_st.rdata = 32'(DEPTH5) << `ID_SIZE_LSB | 32'h1;
        `OFF_ACT: next_st.rdata = {31'h0, st.ch != CH_IDLE};
        `OFF_FREE: next_st.rdata = {27'h0, fq.free};
        `OFF_BASE: next_st.rdata = st.prog_base;
        `OFF_SC: next_st.rdata = st.prog_sc;
        `OFF_TTB: next_st.rdata = {2'h0, st.prog_ttb};
        `OFF_CTX: next_st.rdata = {23'h0, st.prog_ctx};
        default: next_st.rdata = '0;
      endcase
    end

    // preload channel
    case (st.ch)
      CH_IDLE: begin
        if (fq.pop && fq.head.valid && fq.head.count != '0 && !(tlb_inval_tag && tag_match(fq.head, tlb_tag))) begin
          next_st.cur = fq.head;
          next_st.ch = CH_XLAT;
        end
      end
      CH_XLAT: begin
        if (xlat_done && xlat_abort) begin
          next_st.cur = next_block(st.cur);
          next_st.ch = after_block(st.cur);
        end else if (xlat_done) begin
          next_st.hint_addr = xlat_pa;
          next_st.ch = CH_ISSUE;
        end
      end
      CH_ISSUE: begin
        if (ple_take) begin
          next_st.cur = next_block(st.cur);
          next_st.ch = after_block(st.cur);
        end
      end
      default: next_st.ch = CH_IDLE;
    endcase
    if (flush_all || chan_hit) begin
      next_st.ch = CH_IDLE;
    end

    // read address stage; hints carry no burst, no data comes back
    if (arready) begin
      next_st.arv = 1'b0;
    end
    if (rd_step) begin
      next_st.arv = 1'b1;
      next_st.araddr = core_ar_addr;
      next_st.aruser = {2'b00, core_ar_attr, core_ar_shared};
      next_st.arprot = {1'b0, nonsecure_flag, rd_priv};
    end else if (ple_take) begin
      next_st.arv = 1'b1;
      next_st.araddr = st.hint_addr;
      next_st.aruser = HINT_USER;
      next_st.arprot = {1'b0, st.cur.ns, 1'b1};
    end else if (auto_take) begin
      next_st.arv = 1'b1;
      next_st.araddr = st.pf_addr;
      next_st.aruser = HINT_USER;
      next_st.arprot = {1'b0, nonsecure_flag, 1'b1};
      next_st.pf_pend = 1'b0;
    end

    // stride detector on coherent reads
    if (!auto_on) begin
      next_st.pf_pend = 1'b0;
    end else if (rd_step && core_ar_shared) begin
      next_st.pf_last = core_ar_addr;
      next_st.pf_stride = rd_delta;
      if (rd_delta == st.pf_stride && rd_delta != '0) begin
        next_st.pf_pend = 1'b1;
        next_st.pf_addr = core_ar_addr + rd_delta;
      end
    end

    // write address stage
    if (awready) begin
      next_st.awv = 1'b0;
    end
    if (core_aw_valid && aw_free) begin
      next_st.awv = 1'b1;
      next_st.awaddr = core_aw_addr;
      next_st.awuser = {1'b1, core_aw_zero_line && st.aux[`AUX_ZL_BIT], 2'b00,
                        core_aw_attr, core_aw_shared};
      next_st.awprot = {1'b0, nonsecure_flag, wr_priv};
    end

    // sticky: a later barrier never re-enables merging
    if (data_sync_barrier) begin
      next_st.dsb_seen = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
      st.aux <= `AUX_RST;
      st.ch <= CH_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence core_rd_taken;
    core_ar_valid && core_ar_ready;
  endsequence
  sequence core_wr_taken;
    core_aw_valid && core_aw_ready;
  endsequence
  sequence xlat_aborted;
    st.ch == CH_XLAT && xlat_done && xlat_abort && !flush_all && !chan_hit;
  endsequence

  core_no_hint_a: assert property (core_rd_taken |=> arvalid && !aruser[`ARU_HINT])
    else $error("core read carries hint bit");
  ple_hint_a: assert property (ple_take |=> arvalid && aruser == HINT_USER && araddr == $past(st.hint_addr))
    else $error("preload hint not issued");
  auto_gate_a: assert property (auto_take |=> arvalid && aruser == HINT_USER && araddr == $past(st.pf_addr) && MULTI_CORE)
    else $error("automatic hint in uniprocessor build");
  early_resp_a: assert property (awvalid |-> awuser[`AWU_EARLY] && bready)
    else $error("early response bit missing");
  zero_gate_a: assert property (core_wr_taken and !st.aux[`AUX_ZL_BIT] |=> !awuser[`AWU_ZERO])
    else $error("zero-line mark while disabled");
  wr_prot_a: assert property (core_wr_taken and !core_aw_cacheable && core_aw_unpriv_store |=> !awprot[0])
    else $error("unprivileged store marked privileged");
  cache_wr_prot_a: assert property (core_wr_taken and core_aw_cacheable |=> awprot[0])
    else $error("cacheable write not privileged");
  flush_all_a: assert property (flush_all |=> st.ch == CH_IDLE && fq.free == DEPTH5)
    else $error("flush left channel or entries");
  abort_skip_a: assert property (xlat_aborted |=> st.ch != CH_ISSUE && st.cur.count == $past(st.cur.count) - 1'b1)
    else $error("aborted line not skipped");
  activity_rd_a: assert property (reg_rd && reg_addr == `OFF_ACT |=> reg_rdata[0] == $past(st.ch != CH_IDLE))
    else $error("activity flag wrong");
  merge_block_a: assert property ((sb_mem_strong || sb_mem_device || (sb_unpriv_store && st.dsb_seen))
                                  |-> !sb_merge_ok)
    else $error("ordered or barred store may merge");
endmodule

//--- verif/l2_slave_model.sv
/*
  Level-2 slave and preload address translator at the port's far side.
  Assumes the port's clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module l2_slave_model #(
  parameter logic [31:0] ABORT_VA = 32'h0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic arvalid,
  output logic arready,
  input wire logic awvalid,
  output logic awready,
  output logic bvalid,
  input wire logic xlat_req,
  input wire logic [31:0] xlat_va,
  output logic xlat_done,
  output logic xlat_abort,
  output logic [31:0] xlat_pa
);
  // ==========================================================
  // slave channels and translator
  logic [2:0] cnt;
  // slow mode stalls every other cycle to stretch each request
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      {arready, awready, bvalid, xlat_done, xlat_abort, cnt} <= '0;
      xlat_pa <= '0;
    end else begin
      arready <= !slow || !arready;
      awready <= !slow || !awready;
      bvalid <= awvalid && awready;
      cnt <= (xlat_req && !xlat_done) ? cnt + 3'h1 : 3'h0;
      xlat_done <= xlat_req && !xlat_done && cnt == 3'h7;
      xlat_abort <= xlat_va == ABORT_VA;
      // translation result shows only with done, else a moving pattern
      xlat_pa <= (cnt == 3'h7) ? xlat_va + 32'h10000000 : ~xlat_pa;
    end
  end
endmodule

//--- verif/testbench.sv
/*
  Self-checking bench of the level-2 hint and preload port.
  Assumes the slave model at the far side and a 200 MHz clock.
*/
`timescale 1ns/1ps
`include "l2_hint_params.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h seen %h", n, e, g); end end
module testbench;
  localparam int DEPTH = 8;
  localparam logic [31:0] ABORT_VA = 32'h00000fc0;
  localparam logic [4:0] MT [6] = '{5'b00001, 5'b01000, 5'b00100, 5'b00011, 5'b10010, 5'b00001};
  localparam logic [2:0] FL [4] = '{3'b100, 3'b010, 3'b001, 3'b010};
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, user_mode = 0, nonsecure_flag = 0, slow = 0;
  logic core_ar_valid = 0, core_ar_shared = 0, core_ar_cacheable = 0, core_aw_valid = 0, core_aw_shared = 0;
  logic core_aw_cacheable = 0, core_aw_zero_line = 0, core_aw_unpriv_store = 0, sb_mem_strong = 0;
  logic sb_mem_device = 0, sb_unpriv_store = 0, data_sync_barrier = 0, mmu_cfg_write = 0;
  logic tlb_inval_tag = 0, tlb_inval_all = 0, rd_d = 0;
  logic [7:0] reg_addr = 0, tlb_tag = 0, ctag = 0, xlat_tag;
  logic [31:0] reg_wdata = 0, core_ar_addr = 0, core_aw_addr = 0, reg_rdata, araddr, awaddr, xlat_va, xlat_pa;
  logic [3:0] core_ar_attr = 0, core_aw_attr = 0;
  logic [29:0] xlat_ttb;
  logic [6:0] aruser;
  logic [8:0] awuser;
  logic [2:0] arprot, awprot;
  logic core_ar_ready, core_aw_ready, sb_merge_ok, xlat_req, xlat_nonsecure, xlat_done, xlat_abort;
  logic arvalid, arready, awvalid, awready, bvalid, bready;
  logic [43:0] arq[$], awq[$], rq[$], e;
  int seed = 32'h7ad4c92a;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  l2_hint_and_preload_port #(.DEPTH(DEPTH)) u_dut (.*);
  l2_slave_model #(.ABORT_VA(ABORT_VA)) u_l2 (.*);

  always #2.5 clk_sys = ~clk_sys;

  // ==========================================================
  // result watcher: settled values sampled at the falling edge
  always @(negedge clk_sys) begin
    if (rd_d) begin
      e = rq.size() ? rq.pop_front() : '1;
      `CHK("reg_rdata", e, {12'h0, reg_rdata})
    end
    rd_d <= reg_rd;
    if (arvalid && arready) begin
      e = arq.size() ? arq.pop_front() : '1;
      `CHK("ar", e, {araddr, aruser, arprot, 2'b00})
    end
    if (awvalid && awready) begin
      e = awq.size() ? awq.pop_front() : '1;
      `CHK("aw", e, {awaddr, awuser, awprot})
    end
    if (xlat_req) begin
      `CHK("xlat_ctx", {5'h0, 30'h2abcdef0, ctag, 1'b1}, {5'h0, xlat_ttb, xlat_tag, xlat_nonsecure})
    end
  end

  // ==========================================================
  // drivers, entered just after a rising edge
  task automatic tick(input int n);
    {reg_wr, reg_rd, core_ar_valid, core_aw_valid, mmu_cfg_write, tlb_inval_tag, tlb_inval_all} <= '0;
    data_sync_barrier <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b10, a, d};
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back({12'h0, x});
    {reg_wr, reg_rd, reg_addr} <= {2'b01, a};
    @(posedge clk_sys);
  endtask

  // f = {ns, user, shared, attr, cacheable}; a[0] zero line, a[1] unprivileged store
  task automatic core(input bit w, input logic [31:0] a, input logic [7:0] f, input bit zl_on);
    {nonsecure_flag, user_mode} <= f[7:6];
    if (w) begin
      awq.push_back({a, 1'b1, a[0] & zl_on, 2'b00, f[4:1], f[5], 1'b0, f[7], f[0] || (!f[6] && !a[1])});
      core_ar_valid <= 1'b0;
      {core_aw_valid, core_aw_addr, core_aw_attr, core_aw_shared, core_aw_cacheable} <= {1'b1, a, f[4:1], f[5], f[0]};
      {core_aw_zero_line, core_aw_unpriv_store} <= {a[0], a[1]};
      @(negedge clk_sys);
      while (!core_aw_ready) @(negedge clk_sys);
    end else begin
      arq.push_back({a, 2'b00, f[4:1], f[5], 1'b0, f[7], !f[6], 2'b00});
      core_aw_valid <= 1'b0;
      {core_ar_valid, core_ar_addr, core_ar_attr, core_ar_shared, core_ar_cacheable} <= {1'b1, a, f[4:1], f[5], f[0]};
      @(negedge clk_sys);
      while (!core_ar_ready) @(negedge clk_sys);
    end
    @(posedge clk_sys);
  endtask

  task automatic prog(input logic [31:0] b, input logic [15:0] s, input logic [11:0] n, input bit hit);
    wr(`OFF_BASE, b);
    wr(`OFF_SC, {4'h0, n, s});
    wr(`OFF_TTB, 32'h2abcdef0);
    wr(`OFF_CTX, {23'h0, 1'b1, ctag});
    wr(`OFF_GO, 32'h0);
    for (int k = 0; k < n; k++) begin
      if (hit && b + 32'(k) * s != ABORT_VA) arq.push_back({b + 32'(k) * s + 32'h10000000, 7'h20, 3'b011, 2'b00});
    end
  endtask

  task automatic complete_run();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`OFF_AUX, 32'h0);
    rd(`OFF_ID, {11'h0, 5'(DEPTH), 15'h0, 1'b1});
    rd(`OFF_ACT, 32'h0);
    rd(`OFF_FREE, DEPTH);
    wr(`OFF_AUX, '1);
    wr(8'h30, '1);
    rd(`OFF_AUX, 32'ha);
    rd(8'h30, 32'h0);
    for (int p = 0; p < 2; p++) begin
      wr(`OFF_AUX, p ? 32'h8 : 32'h0);
      tick(1);
      for (int i = 0; i < 6; i++) begin
        slow <= i[0];
        core(1'b0, $random(seed), 8'($random(seed)), p[0]);
        core(1'b1, $random(seed), 8'($random(seed)), p[0]);
      end
      tick(4);
    end
    for (int i = 0; i < 6; i++) begin
      {data_sync_barrier, sb_mem_strong, sb_mem_device, sb_unpriv_store} <= MT[i][4:1];
      @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK("merge", 44'(MT[i][0]), 44'(sb_merge_ok))
      @(posedge clk_sys);
    end
    tick(1);
    // crosses a page at 0x1000 and loses one line to an abort
    ctag = 8'h5a;
    slow <= 1'b1;
    prog(32'h00000f80, 16'h0040, 12'h5, 1'b1);
    rd(`OFF_SC, {4'h0, 12'h5, 16'h0040});
    rd(`OFF_CTX, {23'h0, 1'b1, 8'h5a});
    tick(3);
    rd(`OFF_ACT, 32'h1);
    tick(0);
    while (arq.size() != 0) @(posedge clk_sys);
    tick(20);
    rd(`OFF_ACT, 32'h0);
    rd(`OFF_FREE, DEPTH);
    for (int k = 0; k < 4; k++) begin
      ctag = 8'h33;
      prog(32'h4000, 16'h0040, 12'h2, k == 3);
      prog(32'h8000, 16'h0040, 12'h2, k == 3);
      tlb_tag <= (k == 1) ? 8'h33 : 8'h44;
      tick(0);
      @(negedge clk_sys);
      while (!xlat_req) @(negedge clk_sys);
      @(posedge clk_sys);
      {mmu_cfg_write, tlb_inval_tag, tlb_inval_all} <= FL[k];
      @(posedge clk_sys);
      tick(150);
      rd(`OFF_FREE, DEPTH);
      `CHK("left", 44'h0, 44'(arq.size()))
    end
    slow <= 1'b0;
    wr(`OFF_AUX, 32'h2);
    tick(1);
    for (int i = 0; i < 3; i++) begin
      core(1'b0, 32'h2000 + 32'(i) * 32'h40, 8'h23, 1'b0);
    end
    arq.push_back({32'h20c0, 7'h20, 3'b001, 2'b00});
    tick(30);
    `CHK("auto", 44'h0, 44'(arq.size()))
    complete_run();
  end
endmodule
